// file: rtl/sof_bitclk_div.v
// Bit clock divider: filter clock divided by one to thirty-two
`default_nettype none
module sof_bitclk_div
(
  input wire mclk,
  input wire rst,
  input wire [4:0] ratio_m1,
  output wire bit_tick,
  output wire bit_clk_lvl
);
  // ==========================================================
  // Period counter
  reg [4:0] cnt_ff;
  reg clk_ff;
  wire [4:0] nxt_cnt;
  wire [5:0] hi_len;
  // Ratio may shrink mid period, so compare with >= to avoid a 32-cycle lap
  assign bit_tick = (cnt_ff >= ratio_m1);
  assign nxt_cnt = bit_tick ? 5'h00 : cnt_ff + 5'h01;
  // High phase (n+1)/2, low phase n/2, both rounded down; equal halves when n is even
  assign hi_len = ({1'b0, ratio_m1} + 6'h02) >> 1;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_ff <= 5'h00;
      clk_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      clk_ff <= ({1'b0, nxt_cnt} < hi_len);
    end
  end
  assign bit_clk_lvl = clk_ff;
endmodule // sof_bitclk_div
`default_nettype wire

// file: rtl/sof_formatter.v
// Serial output formatter: formats filter results and shifts them out with bit clock and word sync
// Function
// - Output words are programmable from eight to thirty-two bits long.
// - Each word is shifted out either most or least significant bit first.
// - The result is rounded or truncated to the output length as configured.
// - Output words are coded in two's complement or offset binary.
// - When enabled, the value is multiplied by two before serialization.
// - The bit clock divides the filter clock by one to thirty-two and data changes with it.
// - Even ratios give a bit clock with equal high and low times.
// - Odd ratio n above one gives (n+1)/2 clocks high and (n-1)/2 clocks low.
// - Word sync is high one bit period before the first bit of each word, marking word boundaries.
// - Data are fractional two's complement, top bit weighing minus one.
// - Words shorter than twenty-four bits occupy the top of the internal 24-bit word.
`include "sof_regs.vh"
`default_nettype none
module sof_formatter
(
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire [`SOF_INT_W-1:0] res_data,
  input wire res_valid,
  output wire res_ready,
  output wire serial_data_out,
  output wire bit_clock_out,
  output wire word_sync_out
);
  // ==========================================================
  // States
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SYNC = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  // ==========================================================
  // Functions
  // Out-of-range lengths are clamped so the shifter never runs short or long
  function [5:0] clamp_len;
    input [5:0] len;
    begin
      if (len < `SOF_LEN_MIN)
        clamp_len = `SOF_LEN_MIN;
      else if (len > `SOF_LEN_MAX)
        clamp_len = `SOF_LEN_MAX;
      else
        clamp_len = len;
    end
  endfunction

  // Returns the word left-aligned in 32 bits, low bits cleared
  function [31:0] fmt_word;
    input [`SOF_INT_W-1:0] d;
    input [5:0] len;
    input rnd;
    input scale2;
    input offs;
    reg [31:0] x;
    reg [31:0] s;
    reg [31:0] half;
    reg [31:0] mask;
    reg [32:0] sum;
    reg [31:0] r;
    begin
      // Fraction with MSB weight -1 sits at the top of the word
      x = {d, {(32-`SOF_INT_W){1'b0}}};
      // Doubling a value whose top two bits differ would flip its sign, so it is clipped
      if (scale2 && (x[31] != x[30]))
        s = x[31] ? 32'h80000000 : 32'h7fffffff;
      else if (scale2)
        s = {x[30:0], 1'b0};
      else
        s = x;
      half = 32'h80000000 >> len;
      mask = ~(32'hffffffff >> len);
      sum = {s[31], s} + {1'b0, half};
      // Rounding can only overflow upward; saturate rather than wrap
      if (!rnd)
        r = s;
      else if (!s[31] && sum[31])
        r = 32'h7fffffff;
      else
        r = sum[31:0];
      r = r & mask;
      fmt_word = offs ? (r ^ 32'h80000000) : r;
    end
  endfunction

  // ==========================================================
  // Configuration registers
  reg [5:0] len_ff;
  reg lsb_first_ff;
  reg round_ff;
  reg offs_ff;
  reg scale2_ff;
  reg [4:0] div_ff;
  reg [31:0] rdata_ff;

  // ==========================================================
  // Datapath registers
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`SOF_INT_W-1:0] hold_ff;
  reg hold_vld_ff;
  reg [31:0] sh_ff;
  reg [5:0] bits_left_ff;
  reg lsb_ord_ff;
  reg dout_ff;
  reg sync_ff;
  // Word counter wraps; it serves only as a progress hint
  reg [15:0] count_ff;

  wire bit_tick;
  wire bit_clk_lvl;
  wire div_one;
  wire [5:0] eff_len;
  wire [31:0] word_left;
  wire [31:0] word_load;
  wire load_now;
  wire take_res;
  wire [31:0] sh_src;
  wire ord_src;
  wire shift_now;
  wire [31:0] status_val;

  // ==========================================================
  // Bit clock
  // Divider counts filter clocks; its tick opens every bit period
  sof_bitclk_div u_div
  (
    .mclk(mclk),
    .rst(rst),
    .ratio_m1(div_ff),
    .bit_tick(bit_tick),
    .bit_clk_lvl(bit_clk_lvl)
  );

  // Divide by one cannot come from a flop; the filter clock itself goes out
  assign div_one = (div_ff == 5'h00);
  assign bit_clock_out = div_one ? mclk : bit_clk_lvl;

  // ==========================================================
  // Input holding register
  // Only one word is held; the engine stalls on res_ready until it is taken
  assign res_ready = !hold_vld_ff;
  assign take_res = res_valid && !hold_vld_ff;

  // ==========================================================
  // Word formatting at load time
  assign eff_len = clamp_len(len_ff);
  assign word_left = fmt_word(hold_ff, eff_len, round_ff, scale2_ff, offs_ff);
  // LSB-first words are right aligned so bit 0 leaves first
  assign word_load = lsb_first_ff ? (word_left >> (6'h20 - eff_len)) : word_left;
  assign load_now = bit_tick && (state_ff == ST_SYNC);
  assign sh_src = load_now ? word_load : sh_ff;
  assign ord_src = load_now ? lsb_first_ff : lsb_ord_ff;
  // A tick inside a word with bits still to send moves the next bit out
  assign shift_now = bit_tick && (state_ff == ST_SHIFT) && (bits_left_ff != 6'h00);

  // ==========================================================
  // Sequencer next state
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (bit_tick && hold_vld_ff)
          nxt_state = ST_SYNC;
      end
      ST_SYNC:
      begin
        if (bit_tick)
          nxt_state = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        // Next sync overlaps the last bit so words run back to back
        if (bit_tick && (bits_left_ff == 6'h01) && hold_vld_ff)
          nxt_state = ST_SYNC;
        else if (bit_tick && (bits_left_ff == 6'h00))
          nxt_state = hold_vld_ff ? ST_SYNC : ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Sequencer and shifter
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      hold_ff <= {`SOF_INT_W{1'b0}};
      hold_vld_ff <= 1'b0;
      sh_ff <= 32'h00000000;
      bits_left_ff <= 6'h00;
      lsb_ord_ff <= 1'b0;
      dout_ff <= 1'b0;
      sync_ff <= 1'b0;
      count_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (take_res)
      begin
        hold_ff <= res_data;
        hold_vld_ff <= 1'b1;
      end
      else if (load_now)
        hold_vld_ff <= 1'b0;
      // Sync rises on the tick that opens the period before bit one
      if (bit_tick)
        sync_ff <= (nxt_state == ST_SYNC);
      if (load_now)
      begin
        lsb_ord_ff <= lsb_first_ff;
        bits_left_ff <= eff_len - 6'h01;
        count_ff <= count_ff + 16'h0001;
      end
      else if (shift_now)
        bits_left_ff <= bits_left_ff - 6'h01;
      if (load_now || shift_now)
      begin
        // Data move on the same filter clock edge that raises the bit clock
        dout_ff <= ord_src ? sh_src[0] : sh_src[31];
        sh_ff <= ord_src ? (sh_src >> 1) : (sh_src << 1);
      end
      else if (bit_tick && (nxt_state == ST_IDLE))
        dout_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Link outputs
  assign serial_data_out = dout_ff;
  assign word_sync_out = sync_ff;

  // ==========================================================
  // Register writes
  // New format settings take effect at the next word load, never mid word; a new ratio reaches the divider at once
  // Writes to the status offset or to unmapped offsets are dropped
  always @(posedge mclk)
  begin
    if (rst)
    begin
      len_ff <= `SOF_LEN_RST;
      lsb_first_ff <= 1'b0;
      round_ff <= 1'b0;
      offs_ff <= 1'b0;
      scale2_ff <= 1'b0;
      div_ff <= `SOF_DIV_RST;
    end
    else if (reg_wr && (reg_addr == `SOF_FORMAT_OFS))
    begin
      len_ff <= reg_wdata[`SOF_LEN_MSB:`SOF_LEN_LSB];
      lsb_first_ff <= reg_wdata[`SOF_LSB_FIRST_BIT];
      round_ff <= reg_wdata[`SOF_ROUND_BIT];
      offs_ff <= reg_wdata[`SOF_OFFSET_BIN_BIT];
      scale2_ff <= reg_wdata[`SOF_SCALE2_BIT];
    end
    else if (reg_wr && (reg_addr == `SOF_TIMING_OFS))
      div_ff <= reg_wdata[`SOF_DIV_MSB:`SOF_DIV_LSB];
  end

  // ==========================================================
  // Register reads
  // Status shows sequencer state, held flag and the load counter
  assign status_val = {count_ff, 13'h0000, hold_vld_ff, state_ff};

  // Read data stand for one cycle only; unmapped addresses read zero
  always @(posedge mclk)
  begin
    if (rst)
      rdata_ff <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SOF_FORMAT_OFS:
          rdata_ff <= {20'h00000, scale2_ff, offs_ff, round_ff, lsb_first_ff, 2'b00, len_ff};
        `SOF_TIMING_OFS:
          rdata_ff <= {27'h0000000, div_ff};
        `SOF_STATUS_OFS:
          rdata_ff <= status_val;
        default:
          rdata_ff <= 32'h00000000;
      endcase
    end
    else
      rdata_ff <= 32'h00000000;
  end

  assign reg_rdata = rdata_ff;
endmodule // sof_formatter
`default_nettype wire

// file: rtl/sof_regs.vh
// Register offsets, field positions, reset values and constants of the serial output formatter
`ifndef SOF_REGS_VH
`define SOF_REGS_VH
// ==========================================================
// Register offsets (byte addresses)
`define SOF_FORMAT_OFS 8'h00
`define SOF_TIMING_OFS 8'h04
`define SOF_STATUS_OFS 8'h08
// ==========================================================
// Format register fields
`define SOF_LEN_LSB 0
`define SOF_LEN_MSB 5
`define SOF_LSB_FIRST_BIT 8
`define SOF_ROUND_BIT 9
`define SOF_OFFSET_BIN_BIT 10
`define SOF_SCALE2_BIT 11
// ==========================================================
// Timing register fields
`define SOF_DIV_LSB 0
`define SOF_DIV_MSB 4
// ==========================================================
// Status register fields
`define SOF_STATE_LSB 0
`define SOF_STATE_MSB 1
`define SOF_HOLD_BIT 2
`define SOF_COUNT_LSB 16
`define SOF_COUNT_MSB 31
// ==========================================================
// Reset values and limits
`define SOF_LEN_RST 6'h18
`define SOF_DIV_RST 5'h01
`define SOF_LEN_MIN 6'h08
`define SOF_LEN_MAX 6'h20
`define SOF_INT_W 24
`endif

// file: verification/sof_dsp_rx.sv
// Receive port model of a DSP collecting formatter words
`default_nettype none
module sof_dsp_rx
(
  input wire logic bit_clock_out,
  input wire logic word_sync_out,
  input wire logic serial_data_out,
  input wire logic [5:0] word_len,
  output var logic [31:0] rx_word,
  output var int rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Receiver
  logic [31:0] sh;
  logic [5:0] got;
  logic armed = 1'b0;
  initial rx_count = 0;
  // Falling edge gives half a bit of margin on both sides for even ratios and divide by one; odd ratios above one are uneven
  always @(negedge bit_clock_out)
  begin
    if (armed)
    begin
      sh = {sh[30:0], serial_data_out};
      got = got + 6'h01;
      armed = got != word_len;
      if (!armed)
      begin
        rx_word = sh;
        rx_count = rx_count + 1;
      end
    end
    if (word_sync_out)
    begin
      armed = 1'b1;
      got = 6'h00;
      sh = 32'h0;
    end
  end
endmodule // sof_dsp_rx
`default_nettype wire

// file: verification/sof_formatter_monitor.sv
// Port checker of the serial output formatter
`include "sof_regs.vh"
`default_nettype none
module sof_formatter_monitor
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [23:0] res_data,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic serial_data_out,
  input wire logic bit_clock_out,
  input wire logic word_sync_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Checks
  logic [4:0] div_ff;
  logic [6:0] set_ff;
  logic [5:0] hi_ff, lo_ff, syn_ff;
  wire logic ok = set_ff[6];
  wire logic tw = reg_wr && reg_addr == `SOF_TIMING_OFS;
  wire logic [5:0] n = {1'b0, div_ff} + 6'h01;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Old period may finish after a ratio write, so edge checks wait 64 cycles
  always_ff @(posedge mclk)
  begin
    set_ff <= (rst || tw) ? 7'h00 : (ok ? set_ff : set_ff + 7'h01);
    div_ff <= rst ? 5'h01 : (tw ? reg_wdata[4:0] : div_ff);
    hi_ff <= bit_clock_out ? hi_ff + 6'h01 : 6'h00;
    lo_ff <= bit_clock_out ? 6'h00 : lo_ff + 6'h01;
    syn_ff <= word_sync_out ? syn_ff + 6'h01 : 6'h00;
  end
  property p_dat; ok && div_ff != 5'h00 && $changed(serial_data_out) |-> $rose(bit_clock_out); endproperty
  a_dat: assert property (p_dat) else $error("data off edge");
  property p_syn; ok && div_ff != 5'h00 && $changed(word_sync_out) |-> $rose(bit_clock_out); endproperty
  a_syn: assert property (p_syn) else $error("sync off edge");
  property p_slen; ok && $fell(word_sync_out) |-> syn_ff == n; endproperty
  a_slen: assert property (p_slen) else $error("sync length");
  property p_hi; ok && div_ff != 5'h00 && $fell(bit_clock_out) |-> hi_ff == (n + 6'h01) >> 1; endproperty
  a_hi: assert property (p_hi) else $error("clock high");
  property p_lo; ok && div_ff != 5'h00 && $rose(bit_clock_out) |-> lo_ff == n >> 1; endproperty
  a_lo: assert property (p_lo) else $error("clock low");
  property p_take; res_valid && res_ready |=> !res_ready; endproperty
  a_take: assert property (p_take) else $error("ready after take");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data idle");
  property p_div; $past(reg_rd) && $past(reg_addr) == `SOF_TIMING_OFS |-> reg_rdata == {27'h0, div_ff}; endproperty
  a_div: assert property (p_div) else $error("ratio readback");
  c_syn: cover property ($rose(word_sync_out));
  c_full: cover property (res_valid && !res_ready);
  c_max: cover property (ok && div_ff == 5'h1f && $fell(bit_clock_out));
endmodule // sof_formatter_monitor
bind sof_formatter sof_formatter_monitor u_mon (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .res_data(res_data),
  .res_valid(res_valid), .res_ready(res_ready), .serial_data_out(serial_data_out),
  .bit_clock_out(bit_clock_out), .word_sync_out(word_sync_out));
`default_nettype wire

// file: verification/test_serial_output_formatter.sv
// Self-checking bench of the serial output formatter
`include "sof_regs.vh"
`default_nettype none
module test_serial_output_formatter;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Stimulus
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, res_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rx_word;
  logic [23:0] res_data = 24'h0;
  logic [5:0] rx_len = 6'h08;
  logic res_ready, serial_data_out, bit_clock_out, word_sync_out;
  int rx_count, n_mismatch = 0, compares = 0, cyc = 0;
  sof_formatter dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready),
    .serial_data_out(serial_data_out), .bit_clock_out(bit_clock_out), .word_sync_out(word_sync_out));
  sof_dsp_rx u_rx (.bit_clock_out(bit_clock_out), .word_sync_out(word_sync_out),
    .serial_data_out(serial_data_out), .word_len(rx_len), .rx_word(rx_word), .rx_count(rx_count));
  // One clock feeds engine and formatter, so bit timing is exact
  initial forever #10 mclk = ~mclk;
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic send(input logic [23:0] d);
    res_data <= d;
    res_valid <= 1'b1;
    do @(posedge mclk); while (res_ready !== 1'b1);
    res_valid <= 1'b0;
    @(posedge mclk);
  endtask
  // Options are scale, offset, round, lsb first from the top bit down
  task automatic word(input logic [5:0] len, input logic [3:0] opt, input logic [23:0] d, output logic [31:0] w);
    int c0;
    wr(`SOF_FORMAT_OFS, {20'h0, opt, 2'b00, len});
    rx_len = len;
    c0 = rx_count;
    send(d);
    while (rx_count == c0) @(posedge mclk);
    w = rx_word;
  endtask
  task automatic t_regs;
    logic [31:0] v;
    rd(`SOF_FORMAT_OFS, v);
    check("format", v, 32'h18);
    rd(8'h0c, v);
    check("unmapped", v, 32'h0);
    wr(`SOF_TIMING_OFS, 32'hffffffff);
    rd(`SOF_TIMING_OFS, v);
    check("ratio", v, 32'h1f);
    wr(`SOF_TIMING_OFS, 32'h1);
  endtask
  task automatic t_shape;
    logic [31:0] w;
    word(6'h08, 4'h0, 24'h12c000, w);
    check("len 8", w, 32'h12);
    word(6'h20, 4'h0, 24'h9abcde, w);
    check("len 32", w, 32'h9abcde00);
    word(6'h0c, 4'h1, 24'h9abcde, w);
    check("lsb first", w, 32'hd59);
    word(6'h08, 4'h2, 24'h12c000, w);
    check("round", w, 32'h13);
    word(6'h08, 4'h2, 24'h7ff000, w);
    check("round clamp", w, 32'h7f);
    word(6'h08, 4'h4, 24'h9abcde, w);
    check("offset", w, 32'h1a);
    word(6'h10, 4'h8, 24'h123400, w);
    check("scale", w, 32'h2468);
    word(6'h10, 4'h8, 24'ha00000, w);
    check("scale clamp", w, 32'h8000);
  endtask
  task automatic t_ratio;
    logic [31:0] w;
    wr(`SOF_TIMING_OFS, 32'h0);
    word(6'h08, 4'h0, 24'h5a0000, w);
    check("by one", w, 32'h5a);
    wr(`SOF_TIMING_OFS, 32'h2);
    word(6'h08, 4'h0, 24'hc30000, w);
    check("by three", w, 32'hc3);
    wr(`SOF_TIMING_OFS, 32'h1);
  endtask
  task automatic t_back;
    int c0;
    logic [31:0] v;
    c0 = rx_count;
    send(24'ha50000);
    send(24'h3c0000);
    while (rx_count < c0 + 2) @(posedge mclk);
    check("words", rx_count - c0, 2);
    check("second", rx_word, 32'h3c);
    // Twelve words loaded so far, sequencer idle, nothing held
    repeat (8) @(posedge mclk);
    rd(`SOF_STATUS_OFS, v);
    check("status", v, 32'h000c0000);
  endtask
  task automatic duty(input int n);
    int hi, lo;
    wr(`SOF_TIMING_OFS, n - 1);
    repeat (80) @(posedge mclk);
    while (bit_clock_out !== 1'b1) @(posedge mclk);
    while (bit_clock_out !== 1'b0) @(posedge mclk);
    for (lo = 0; bit_clock_out === 1'b0; lo++) @(posedge mclk);
    for (hi = 0; bit_clock_out === 1'b1; hi++) @(posedge mclk);
    check("high", hi, (n + 1) / 2);
    check("low", lo, n / 2);
  endtask
  task automatic t_duty;
    int ns[5] = '{2, 3, 4, 31, 32};
    foreach (ns[i]) duty(ns[i]);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_shape();
    t_ratio();
    t_back();
    t_duty();
    stop_test();
  end
endmodule // test_serial_output_formatter
`default_nettype wire
